// [hw/spcfg_pkg.sv]
// Constants and types shared by the serial port configuration register group
package spcfg_pkg;
   // Register offsets
   localparam logic [15:0] OFF_SERIAL_CFG = 16'h0000;
   localparam logic [15:0] OFF_READBACK = 16'h0004;
   localparam logic [15:0] OFF_COMMIT = 16'h0005;
   localparam logic [15:0] OFF_TAG_LO = 16'h0006;
   localparam logic [15:0] OFF_TAG_HI = 16'h0007;
   localparam logic [15:0] OFF_SI_REV = 16'h000A;
   localparam logic [15:0] OFF_FAM_LO = 16'h000C;
   localparam logic [15:0] OFF_FAM_HI = 16'h000D;
   // Field positions
   localparam int BIT_OUT_PIN_EN = 7;
   localparam int BIT_LSB_FIRST = 6;
   localparam int BIT_SOFT_RESET = 5;
   localparam int BIT_READ_PENDING = 0;
   localparam int BIT_COMMIT = 0;
   // Reset values
   localparam logic [7:0] RST_SERIAL_CFG = 8'h00;
   localparam logic [7:0] RST_READBACK = 8'h00;
   localparam logic [7:0] RST_TAG = 8'h00;
   // Writable bit masks; other bits are reserved and read zero
   localparam logic [7:0] MASK_SERIAL_CFG = 8'hE0;
   localparam logic [7:0] MASK_READBACK = 8'h01;
   // Frame shape and soft reset length
   localparam int CMD_BITS = 16;
   localparam int SOFT_RESET_CYCLES = 4;
   // Link-side frame states
   typedef enum logic [1:0] {ST_CMD, ST_DATA} frame_state_t;
endpackage : spcfg_pkg

// [hw/cfg_port_if.sv]
// Register access carrier between the link-side shifter and the register file
interface cfg_port_if;
   logic wr_tgl;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] cfg_mirror;
   modport link (output wr_tgl, output addr, output wdata, input rdata,
      input cfg_mirror);
   modport regs (input wr_tgl, input addr, input wdata, output rdata,
      output cfg_mirror);
endinterface : cfg_port_if

// [hw/sync2.sv]
// Two-flop level synchroniser
module sync2 #(parameter int W = 1) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   // First stage feeds only the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // sync2

// [hw/spi_link.sv]
// Serial-clock side: frame shifter, address stepping and read/write driver
module spi_link
   import spcfg_pkg::*;
(
   // Link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe,
   output logic sdo_o,
   output logic sdo_oe,
   input wire logic rst,
   // Register file
   cfg_port_if.link port
);
   frame_state_t st_q;
   logic [4:0] cnt_q;
   logic [15:0] sh_q;
   logic rd_q;
   logic [7:0] out_q;
   logic lsb_first;
   logic four_wire;
   logic [7:0] rbyte;
   logic [7:0] wbyte;

   logic step_q;
   logic [1:0] mode_s;

   // Mode bits come from the core clock; two link edges settle them,
   // long before the command ends and the data phase needs them
   sync2 #(.W(2)) u_msync (
      .clk(sclk),
      .rst(rst),
      .d({port.cfg_mirror[BIT_OUT_PIN_EN],
         port.cfg_mirror[BIT_LSB_FIRST]}),
      .q(mode_s)
   );
   assign four_wire = mode_s[1];
   assign lsb_first = mode_s[0];
   assign wbyte = {sh_q[6:0], sdio_i};

   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) r[i] = v[7-i];
      return r;
   endfunction

   // Multibyte address step follows the order setting
   function automatic logic [15:0] step_addr(input logic [15:0] a,
      input logic up);
      return up ? a + 16'd1 : a - 16'd1;
   endfunction

   // Bit order of the data byte follows the order setting
   assign rbyte = lsb_first ? rev8(wbyte) : wbyte;

   // Shift in command then data bytes; cs_n ends the frame asynchronously
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         st_q <= ST_CMD;
         cnt_q <= '0;
         sh_q <= '0;
         rd_q <= 1'b0;
      end else begin
         sh_q <= {sh_q[14:0], sdio_i};
         if (st_q == ST_CMD) begin
            if (cnt_q == 5'(CMD_BITS - 1)) begin
               rd_q <= sh_q[14];
               st_q <= ST_DATA;
               cnt_q <= '0;
            end else begin
               cnt_q <= cnt_q + 5'd1;
            end
         end else begin
            cnt_q <= (cnt_q == 5'd7) ? 5'd0 : cnt_q + 5'd1;
         end
      end
   end

   // Address load and multibyte stepping, write capture with a toggle.
   // After a write the step waits for the next byte, so the core still
   // finds the written byte's own address when the toggle arrives
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         port.addr <= '0;
         port.wdata <= '0;
         port.wr_tgl <= 1'b0;
         step_q <= 1'b0;
      end else if (!cs_n) begin
         if (st_q == ST_CMD && cnt_q == 5'(CMD_BITS - 1)) begin
            port.addr <= {3'b000, sh_q[11:0], sdio_i};
            step_q <= 1'b0;
         end else if (st_q == ST_DATA && cnt_q == 5'd7) begin
            if (rd_q) begin
               port.addr <= step_addr(port.addr, lsb_first);
            end else begin
               port.wdata <= rbyte;
               port.wr_tgl <= ~port.wr_tgl;
               step_q <= 1'b1;
            end
         end else if (step_q) begin
            step_q <= 1'b0;
            port.addr <= step_addr(port.addr, lsb_first);
         end
      end
   end

   // Read data launched on the falling edge, bit order per setting; the
   // byte is loaded after its first bit, when the core has answered
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         out_q <= '0;
      end else if (rd_q && st_q == ST_DATA && cnt_q == 5'd1) begin
         out_q <= lsb_first ? {1'b0, port.rdata[7:1]}
                            : {port.rdata[6:0], 1'b0};
      end else begin
         out_q <= lsb_first ? {1'b0, out_q[7:1]} : {out_q[6:0], 1'b0};
      end
   end

   // Current output bit; first bit comes straight from the register file
   logic first_bit;
   logic cur_bit;
   assign first_bit = lsb_first ? port.rdata[0] : port.rdata[7];
   assign cur_bit = (cnt_q == 5'd0) ? first_bit
                  : (lsb_first ? out_q[0] : out_q[7]);
   // Output pin choice: shared data line or separate output pin
   assign sdio_o = cur_bit;
   assign sdo_o = cur_bit;
   assign sdio_oe = rd_q && st_q == ST_DATA && !cs_n && !four_wire;
   assign sdo_oe = rd_q && st_q == ST_DATA && !cs_n && four_wire;
endmodule // spi_link

// [hw/serial_port_config_regs.sv]
// Serial port configuration and identification register group
//
// Contract
// - Config bit 7 selects 4-wire output pin
// - Bit 6 set: LSB first, address increments
// - Bit 6 clear: MSB first, address decrements
// - Writing bit 5 resets, starts download
// - Config register excluded from stored settings
// - Readback bit set returns pending buffer values
// - Readback bit clear returns active values
// - Commit copies buffers into active registers
// - Live registers apply at once, others commit
// - Commit bit clears itself after transfer
// - Sixteen-bit user tag, resets to zero
// - User tag only stored and read back
// - Read-only eight-bit silicon revision code
// - Read-only family code, low byte first
module serial_port_config_regs
   import spcfg_pkg::*;
#(
   parameter logic [7:0] SILICON_REV = 8'h5A, // Arbitrary value
   parameter logic [15:0] FAMILY_CODE = 16'hA5C3 // Arbitrary value
) (
   // Core clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe,
   output logic sdo_o,
   output logic sdo_oe,
   // Download request and completion
   input wire logic download_done,
   output logic download_start,
   // Commit to the rest of the device
   output logic commit_pulse,
   // Active settings applied to the device logic
   output logic [7:0] active_cfg,
   output logic four_wire,
   output logic lsb_first
);
   cfg_port_if port ();

   logic [7:0] serial_cfg_q;
   logic [7:0] readback_q;
   logic [7:0] commit_q;
   logic [15:0] tag_q;
   logic [15:0] tag_act_q;
   logic wr_sync;
   logic wr_seen_q;
   logic wr_ev;
   logic [15:0] addr_sync;
   logic [7:0] wdata_sync;
   logic [2:0] rst_cnt_q;
   logic dl_done_s;
   logic dl_wait_q;
   logic [7:0] rdata_q;

   spi_link u_link (
      .sclk(sclk),
      .cs_n(cs_n),
      .sdio_i(sdio_i),
      .sdio_o(sdio_o),
      .sdio_oe(sdio_oe),
      .sdo_o(sdo_o),
      .sdo_oe(sdo_oe),
      .rst(rst),
      .port(port.link)
   );

   // Write toggle crosses as a level; address and data are held stable
   // by the link for a full byte, well over the two-flop latency
   sync2 #(.W(1)) u_wsync (
      .clk(ref_clk),
      .rst(rst),
      .d(port.wr_tgl),
      .q(wr_sync)
   );
   sync2 #(.W(24)) u_dsync (
      .clk(ref_clk),
      .rst(rst),
      .d({port.addr, port.wdata}),
      .q({addr_sync, wdata_sync})
   );
   sync2 #(.W(1)) u_dlsync (
      .clk(ref_clk),
      .rst(rst),
      .d(download_done),
      .q(dl_done_s)
   );

   // Edge of the synchronised toggle marks one write
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_seen_q <= 1'b0;
      end else if (clk_en) begin
         wr_seen_q <= wr_sync;
      end
   end
   assign wr_ev = clk_en && (wr_sync != wr_seen_q);

   // Serial configuration is live: takes effect at once, no commit
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         serial_cfg_q <= RST_SERIAL_CFG;
      end else if (clk_en) begin
         // Bit 5 stays up until the download reports done; placed first
         // so that a new write in the same cycle wins
         if (dl_wait_q && dl_done_s) begin
            serial_cfg_q[BIT_SOFT_RESET] <= 1'b0;
         end
         if (wr_ev && addr_sync == OFF_SERIAL_CFG) begin
            serial_cfg_q <= wdata_sync & MASK_SERIAL_CFG;
         end
      end
   end

   // Soft reset: clear buffered state for a few cycles, then download
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rst_cnt_q <= '0;
         dl_wait_q <= 1'b0;
         download_start <= 1'b0;
      end else if (clk_en) begin
         download_start <= 1'b0;
         if (wr_ev && addr_sync == OFF_SERIAL_CFG &&
             wdata_sync[BIT_SOFT_RESET]) begin
            rst_cnt_q <= 3'(SOFT_RESET_CYCLES);
         end else if (rst_cnt_q != 3'd0) begin
            rst_cnt_q <= rst_cnt_q - 3'd1;
            if (rst_cnt_q == 3'd1) begin
               download_start <= 1'b1;
               dl_wait_q <= 1'b1;
            end
         end else if (dl_wait_q && dl_done_s) begin
            dl_wait_q <= 1'b0;
         end
      end
   end

   // Readback source selection, reserved bits masked
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         readback_q <= RST_READBACK;
      end else if (clk_en) begin
         if (rst_cnt_q != 3'd0) begin
            readback_q <= RST_READBACK;
         end else if (wr_ev && addr_sync == OFF_READBACK) begin
            readback_q <= wdata_sync & MASK_READBACK;
         end
      end
   end

   // Commit bit: set by write of one, cleared after the copy
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         commit_q <= '0;
         commit_pulse <= 1'b0;
      end else if (clk_en) begin
         commit_pulse <= commit_q[BIT_COMMIT];
         if (wr_ev && addr_sync == OFF_COMMIT &&
             wdata_sync[BIT_COMMIT]) begin
            commit_q[BIT_COMMIT] <= 1'b1;
         end else begin
            commit_q[BIT_COMMIT] <= 1'b0;
         end
      end
   end

   // User tag buffer; stored and read back only, drives no function
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tag_q <= {RST_TAG, RST_TAG};
      end else if (clk_en) begin
         if (rst_cnt_q != 3'd0) begin
            tag_q <= {RST_TAG, RST_TAG};
         end else if (wr_ev && addr_sync == OFF_TAG_LO) begin
            tag_q[7:0] <= wdata_sync;
         end else if (wr_ev && addr_sync == OFF_TAG_HI) begin
            tag_q[15:8] <= wdata_sync;
         end
      end
   end

   // Active copy of buffered registers, loaded at commit, cleared by soft reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tag_act_q <= {RST_TAG, RST_TAG};
      end else if (clk_en) begin
         if (rst_cnt_q != 3'd0) begin
            tag_act_q <= {RST_TAG, RST_TAG};
         end else if (commit_q[BIT_COMMIT]) begin
            tag_act_q <= tag_q;
         end
      end
   end

   // Read mux; buffered registers follow the readback source bit
   function automatic logic [7:0] read_mux(input logic [15:0] a,
      input logic pend, input logic [7:0] cfg, input logic [7:0] rb,
      input logic [15:0] tb, input logic [15:0] ta);
      logic [15:0] t;
      t = pend ? tb : ta;
      case (a)
         OFF_SERIAL_CFG: read_mux = cfg;
         OFF_READBACK: read_mux = rb;
         OFF_COMMIT: read_mux = 8'h00;
         OFF_TAG_LO: read_mux = t[7:0];
         OFF_TAG_HI: read_mux = t[15:8];
         OFF_SI_REV: read_mux = SILICON_REV;
         OFF_FAM_LO: read_mux = FAMILY_CODE[7:0];
         OFF_FAM_HI: read_mux = FAMILY_CODE[15:8];
         default: read_mux = 8'h00;
      endcase
   endfunction

   // Read data registered in the core domain
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (clk_en) begin
         rdata_q <= read_mux(addr_sync, readback_q[BIT_READ_PENDING],
            serial_cfg_q, readback_q, tag_q, tag_act_q);
      end
   end
   // Read data and mirror go back into the link domain; the host must
   // let several core cycles pass between address phase and data
   assign port.rdata = rdata_q;
   assign port.cfg_mirror = serial_cfg_q;

   // Settings exposed to the device; config register is never saved
   // to the stored settings, so no save path exists for it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         active_cfg <= '0;
         four_wire <= 1'b0;
         lsb_first <= 1'b0;
      end else if (clk_en) begin
         active_cfg <= serial_cfg_q;
         four_wire <= serial_cfg_q[BIT_OUT_PIN_EN];
         lsb_first <= serial_cfg_q[BIT_LSB_FIRST];
      end
   end
endmodule // serial_port_config_regs

// [test/spcfg_chk.sv]
// Concurrent checks on the register group's top-level ports
module spcfg_chk
   import spcfg_pkg::*;
(
   // Core clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Link pins
   input wire logic cs_n,
   input wire logic sdio_oe,
   input wire logic sdo_oe,
   // Device side
   input wire logic download_start,
   input wire logic commit_pulse,
   input wire logic [7:0] active_cfg,
   input wire logic four_wire,
   input wire logic lsb_first
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Soft reset is seen first, the download kick follows
   sequence s_sr_req; $rose(active_cfg[BIT_SOFT_RESET]); endsequence
   sequence s_dl_kick; ##[1:16] download_start; endsequence
   property p_sr_start; s_sr_req |-> s_dl_kick; endproperty
   property p_sr_clear;
      active_cfg[BIT_SOFT_RESET] |-> ##[1:40] !active_cfg[BIT_SOFT_RESET];
   endproperty
   property p_dl_one; download_start |=> !download_start; endproperty
   property p_cmt_one; commit_pulse |=> !commit_pulse [*4]; endproperty
   // Pin mode level and config copy are loaded on the same edge
   property p_fw_mirror;
      four_wire == active_cfg[BIT_OUT_PIN_EN];
   endproperty
   property p_lsb_mirror;
      $stable(active_cfg) [*2] |-> lsb_first == active_cfg[BIT_LSB_FIRST];
   endproperty
   property p_rsvd; active_cfg[4:0] == 5'h00; endproperty
   property p_sdo_4w; sdo_oe |-> four_wire && !sdio_oe; endproperty
   property p_sdio_3w; sdio_oe |-> !four_wire; endproperty
   property p_oe_cs; (sdio_oe || sdo_oe) |-> !cs_n; endproperty
   a_sr_start: assert property (p_sr_start)
      else $error("no download kick");
   a_sr_clear: assert property (p_sr_clear)
      else $error("soft reset stuck");
   a_dl_one: assert property (p_dl_one)
      else $error("download kick too long");
   a_cmt_one: assert property (p_cmt_one)
      else $error("commit repeated");
   a_fw_mirror: assert property (p_fw_mirror)
      else $error("four wire level wrong");
   a_lsb_mirror: assert property (p_lsb_mirror)
      else $error("bit order level wrong");
   a_rsvd: assert property (p_rsvd)
      else $error("reserved config bits set");
   a_sdo_4w: assert property (p_sdo_4w)
      else $error("output pin used in 3-wire");
   a_sdio_3w: assert property (p_sdio_3w)
      else $error("shared line used in 4-wire");
   a_oe_cs: assert property (p_oe_cs)
      else $error("driving outside a frame");
endmodule // spcfg_chk

bind serial_port_config_regs spcfg_chk i_chk (.ref_clk(ref_clk), .rst(rst),
   .cs_n(cs_n), .sdio_oe(sdio_oe), .sdo_oe(sdo_oe),
   .download_start(download_start), .commit_pulse(commit_pulse),
   .active_cfg(active_cfg), .four_wire(four_wire), .lsb_first(lsb_first));

// [test/spi_host.sv]
// Serial host model that frames single and multibyte register accesses
module spi_host (
   // Link pins
   output logic sclk,
   output logic cs_n,
   output logic sdio_i,
   input wire logic sdio_o,
   input wire logic sdio_oe,
   input wire logic sdo_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic drv = 1'b0;
   bit lsb = 0; // Bit order the device is set to
   bit fw = 0; // Four-wire mode in force
   initial sclk = 1'b0;
   initial cs_n = 1'b1;
   // Released line shows a changing level, never a stale bit
   assign sdio_i = sdio_oe ? sdio_o : drv;
   // Clock stands still outside bits; sample just before the rising edge
   task automatic bit_x(input logic b, output logic s);
      drv = b;
      #3 s = fw ? sdo_o : sdio_i;
      sclk = 1'b1;
      #3 sclk = 1'b0;
   endtask
   // Gaps let each byte span well over five core cycles
   task automatic xfer(input logic rd, input logic [12:0] a, input int n,
      input logic [15:0] w, output logic [15:0] r);
      logic [15:0] c;
      logic s;
      r = '0;
      c = {rd, 2'b00, a};
      cs_n = 1'b0;
      #6;
      for (int i = 15; i >= 0; i--) bit_x(c[i], s);
      for (int k = 0; k < n; k++) begin
         #60;
         for (int i = 0; i < 8; i++) begin
            bit_x(rd ? ~drv : w[8*k + (lsb ? i : 7 - i)], s);
            r[8*k + (lsb ? i : 7 - i)] = s;
         end
      end
      #6 cs_n = 1'b1;
      drv = ~drv;
      #100;
   endtask
endmodule // spi_host

// [test/serial_port_config_regs_tb.sv]
// Self-checking testbench for the serial port configuration registers
module serial_port_config_regs_tb
   import spcfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] SREV = 8'h3C; // Arbitrary value
   localparam logic [15:0] FAM = 16'h6B2E; // Arbitrary value
   logic ref_clk, rst, clk_en, sclk, cs_n, sdio_i, sdio_o, sdio_oe, sdo_o;
   logic sdo_oe, download_done, download_start, commit_pulse;
   logic four_wire, lsb_first;
   logic [7:0] active_cfg;
   logic [15:0] act, v, r;
   int n_fail = 0;
   int cmp_count = 0;
   int n_dl = 0;
   int n_cmt = 0;
   int n;
   int seed = 32'h92EC;
   logic [12:0] ta [9] = '{13'h000, 13'h004, 13'h005, 13'h006, 13'h007,
      13'h00A, 13'h00C, 13'h00D, 13'h008};
   logic [7:0] te [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, SREV,
      FAM[7:0], FAM[15:8], 8'h00};

   serial_port_config_regs #(.SILICON_REV(SREV), .FAMILY_CODE(FAM)) i_dut (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .sclk(sclk),
      .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
      .sdo_o(sdo_o), .sdo_oe(sdo_oe), .download_done(download_done),
      .download_start(download_start), .commit_pulse(commit_pulse),
      .active_cfg(active_cfg), .four_wire(four_wire),
      .lsb_first(lsb_first));
   spi_host i_host (.sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i),
      .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdo_o(sdo_o));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Pulse counters, sampled away from the launching edge
   always @(negedge ref_clk) begin
      n_dl += download_start;
      n_cmt += commit_pulse;
   end

   // Buffered read returns pending or active value
   function automatic logic [7:0] seen(input logic rb,
      input logic [7:0] p, input logic [7:0] a);
      return rb ? p : a;
   endfunction
   task automatic cmpv(input logic [7:0] g, input logic [7:0] e,
      input string m);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
      end
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic [15:0] q;
      i_host.xfer(1'b0, a, 1, {8'h00, d}, q);
   endtask
   task automatic chk(input logic [12:0] a, input logic [7:0] e,
      input string m);
      logic [15:0] q;
      i_host.xfer(1'b1, a, 1, 16'h0000, q);
      cmpv(q[7:0], e, m);
   endtask
   task automatic done(input string m);
      $display("test %s finished", m);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog: the run needs some 30 us
   initial begin
      #200000;
      n_fail++;
      $display("[FAIL] %0t watchdog expired", $time);
      conclude();
   end

   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      download_done = 1'b0;
      act = '0;
      repeat (5) @(negedge ref_clk);
      rst = 1'b0;
      repeat (3) @(negedge ref_clk);
      // Reset values and codes, then writes to read-only places refused
      for (int p = 0; p < 2; p++) begin
         foreach (ta[i]) chk(ta[i], te[i], "reset/ro");
         for (int i = 5; i < 9; i++) wr(ta[i], ~te[i]);
      end
      wr(13'h004, 8'hFF);
      chk(13'h004, 8'h01, "readback mask");
      wr(13'h004, 8'h00);
      wr(13'h005, 8'hFE);
      chk(13'h005, 8'h00, "commit reserved");
      done("ids");
      // Tag through buffer, readback select and commit
      for (int k = 0; k < 4; k++) begin
         v = (k == 0) ? 16'hFFFF : 16'($random(seed));
         wr(13'h006, v[7:0]);
         wr(13'h007, v[15:8]);
         chk(13'h006, seen(1'b0, v[7:0], act[7:0]), "active lo");
         wr(13'h004, 8'h01);
         chk(13'h007, seen(1'b1, v[15:8], act[15:8]), "pending hi");
         wr(13'h004, 8'h00);
         n = n_cmt;
         wr(13'h005, 8'h01);
         act = v;
         cmpv(8'(n_cmt - n), 8'h01, "commit pulse");
         chk(13'h005, 8'h00, "commit clear");
         chk(13'h006, act[7:0], "tag lo");
         chk(13'h007, act[15:8], "tag hi");
      end
      done("commit");
      // Four-wire, LSB first with increment, then back with decrement
      wr(13'h000, 8'hDF);
      repeat (4) @(negedge ref_clk);
      cmpv({four_wire, lsb_first, 6'h00}, 8'hC0, "pins");
      cmpv(active_cfg, 8'hC0, "active cfg");
      i_host.fw = 1;
      i_host.lsb = 1;
      chk(13'h000, 8'hC0, "cfg 4-wire");
      wr(13'h004, 8'h01);
      i_host.xfer(1'b0, 13'h006, 2, 16'hB4A7, r);
      chk(13'h006, 8'hA7, "inc lo");
      chk(13'h007, 8'hB4, "inc hi");
      wr(13'h000, 8'h00);
      i_host.fw = 0;
      i_host.lsb = 0;
      i_host.xfer(1'b0, 13'h007, 2, 16'h3C5E, r);
      chk(13'h007, 8'h5E, "dec hi");
      chk(13'h006, 8'h3C, "dec lo");
      cmpv({four_wire, lsb_first, 6'h00}, 8'h00, "pins off");
      wr(13'h004, 8'h00);
      done("order");
      // Soft reset kicks one download, clears the tag and clears itself
      n = n_dl;
      wr(13'h000, 8'h20);
      for (int i = 0; i < 50 && n_dl == n; i++) @(negedge ref_clk);
      download_done = 1'b1;
      @(negedge ref_clk);
      download_done = 1'b0;
      repeat (20) @(negedge ref_clk);
      cmpv(8'(n_dl - n), 8'h01, "download start");
      chk(13'h000, 8'h00, "soft reset clear");
      chk(13'h006, 8'h00, "tag after soft reset");
      done("soft reset");
      conclude();
   end
endmodule // serial_port_config_regs_tb
